// File: gpio_pin_config.sv
//----------------------------------------------------------------------
// Behaviour
// - Bit 0 set makes the pin an input, clear makes it an output.
// - Bit 1 set inverts between pin and internal logic.
// - Bit 7 set gives an open-drain driver, clear push-pull.
// - Pin 3.7 alternate bit routes address bit 20 mask to the pin.
// - Pin 4.0 alternate bit carries drive density select 0.
// - Pin 4.1 field: GPIO, density select 1, edge interrupt 2, reserved.
// - Pin 4.2 alternate bit drives the active-low power event output.
// - Pin 4.3 field code 11 is edge interrupt 3; code 10 reserved.
// - Five consecutive configuration registers at offsets 3A to 3E.
// - Pin 4.3 code 01 forces non-inverted input and locks until reset.
// - In lock mode the device-disable register is writable only pin-low.
//----------------------------------------------------------------------
// Top of the pin configuration block with an Avalon-MM register slave.
// Assumes pins are asynchronous; rstn covers all power-on and bus resets.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_config
    import gpio_cfg_pkg::*;
#(
    parameter int NPins = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [gpio_cfg_pkg::AddrW+1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Alternate function sources
    input wire logic addressBit20Mask,
    input wire logic driveDensitySelect0,
    input wire logic driveDensitySelect1,
    input wire logic powerEvent,
    // Pins 3.7, 4.0 .. 4.3 in bits 0 to 4
    input wire logic [NPins-1:0] pinIn,
    output logic [NPins-1:0] pinOut,
    output logic [NPins-1:0] pinOe,
    // Status
    output logic [7:0] deviceDisable,
    output logic irq
);
    import gpio_cfg_pkg::*;
    //------------------------------------------------------------------
    // Parameter check
    //------------------------------------------------------------------
    // The pin map and the read mux are laid out for exactly five pins.
    if (NPins != NumPins) begin : gBadPins
        $error("NPins must be 5");
    end
    //------------------------------------------------------------------
    // Reset release
    //------------------------------------------------------------------
    logic rstA_q;
    logic rstnSync;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstA_q <= 1'b0;
            rstnSync <= 1'b0;
        end else begin
            rstA_q <= 1'b1;
            rstnSync <= rstA_q;
        end
    end
    //------------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------------
    logic [7:0] cfg_q [NPins];
    logic [NPins-1:0] gpOut_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic [7:0] devDis_q;
    logic ack_q;
    logic waitReq_q;
    logic [31:0] rd_q;
    logic [NPins-1:0] pOut_q;
    logic [NPins-1:0] pOe_q;
    logic irq_q;
    logic [NPins-1:0] coreIn;
    logic [NPins-1:0] coreOut;
    logic [NPins-1:0] padLvl;
    logic [NPins-1:0] cellOut;
    logic [NPins-1:0] cellOe;
    logic [NPins-1:0] cfgIn;
    logic [NPins-1:0] cfgInv;
    wire [7:0] idx = address[AddrW+1:2];
    wire access = (read || write) && !ack_q;
    // A write lands at the edge where the master sees waitrequest low.
    wire wrEn = write && ack_q && byteenable[0];
    wire rdEn = read && access;
    wire [7:0] wb = writedata[7:0];
    wire [2:0] cfgSel = 3'(idx - IdxPin37);
    wire cfgHit = (idx >= IdxPin37) && (idx <= IdxPin43);
    wire [1:0] alt41 = cfg_q[2][BitAltHi:BitAlt];
    wire [1:0] alt43 = cfg_q[4][BitAltHi:BitAlt];
    wire lock43 = alt43 == Alt43Lock;
    wire devDisWr = wrEn && idx == IdxDevDis && !(lock43 && padLvl[4]);
    //------------------------------------------------------------------
    // Pin cells
    //------------------------------------------------------------------
    assign coreOut[0] = cfg_q[0][BitAlt] ? addressBit20Mask : gpOut_q[0];
    assign coreOut[1] = cfg_q[1][BitAlt] ? driveDensitySelect0 : gpOut_q[1];
    assign coreOut[2] = (alt41 == Alt41Dens1) ? driveDensitySelect1 : gpOut_q[2];
    // Non-inverted output gives an active-low event level on the pin.
    assign coreOut[3] = cfg_q[3][BitAlt] ? !powerEvent : gpOut_q[3];
    assign coreOut[4] = gpOut_q[4];
    genvar g;
    generate
        for (g = 0; g < NPins; g++) begin : gPin
            assign cfgIn[g] = cfg_q[g][BitDir] || (g == 4 && lock43);
            assign cfgInv[g] = cfg_q[g][BitPol] && !(g == 4 && lock43);
            gpio_pin_cell uCell (
                .clk(clk),
                .rstnSync(rstnSync),
                .cfgInput(cfgIn[g]),
                .cfgInvert(cfgInv[g]),
                .cfgOpenDrain(cfg_q[g][BitOdrv]),
                .coreOut(coreOut[g]),
                .coreIn(coreIn[g]),
                .padLevel(padLvl[g]),
                .padIn(pinIn[g]),
                .padOut(cellOut[g]),
                .padOe(cellOe[g])
            );
        end
    endgenerate
    //------------------------------------------------------------------
    // Edge interrupts on pins 4.1 and 4.3
    //------------------------------------------------------------------
    logic [1:0] edgePrev_q;
    wire [1:0] edgeSrc = {coreIn[4], coreIn[2]};
    wire [1:0] edgeEn = {alt43 == Alt43Irq, alt41 == Alt41Irq};
    wire [1:0] edgeEvt = edgeEn & (edgeSrc ^ edgePrev_q);
    wire statRd = rdEn && idx == IdxIrqStat;
    // A new event wins over the clear by read.
    wire [1:0] stat_d = (statRd ? 2'h0 : stat_q) | edgeEvt;
    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    function automatic logic [7:0] cfgNext(input int i, input logic [7:0] old,
                                           input logic [7:0] w);
        logic [7:0] m;
        logic [7:0] n;
        m = (i == 2 || i == 4) ? CfgMask2 : CfgMask1;
        n = w & m;
        if (i == 4 && old[BitAltHi:BitAlt] == Alt43Lock) begin
            n[BitAltHi:BitAlt] = Alt43Lock;
        end
        return n;
    endfunction
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            for (int i = 0; i < NPins; i++) begin
                cfg_q[i] <= CfgReset;
            end
        end else if (wrEn && cfgHit) begin
            cfg_q[cfgSel] <= cfgNext(int'(cfgSel), cfg_q[cfgSel], wb);
        end
    end
    wire outWr = wrEn && idx == IdxPinOut;
    wire maskWr = wrEn && idx == IdxIrqMask;
    // Pin output data for pins in basic I/O mode.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            gpOut_q <= '0;
        end else if (outWr) begin
            gpOut_q <= wb[NPins-1:0];
        end
    end
    // Interrupt mask, one bit per edge source.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            mask_q <= 2'h0;
        end else if (maskWr) begin
            mask_q <= wb[1:0];
        end
    end
    // Device-disable register, guarded by pin 4.3 in lock mode.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            devDis_q <= 8'h00;
        end else if (devDisWr) begin
            devDis_q <= wb;
        end
    end
    // Sticky status and the edge history.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            stat_q <= 2'h0;
            edgePrev_q <= 2'h0;
        end else begin
            stat_q <= stat_d;
            edgePrev_q <= edgeSrc;
        end
    end
    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_d & mask_q);
        end
    end
    // Registered pad drive, so the pins come straight from flops.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            pOut_q <= '0;
            pOe_q <= '0;
        end else begin
            pOut_q <= cellOut;
            pOe_q <= cellOe;
        end
    end
    //------------------------------------------------------------------
    // Read data and handshake
    //------------------------------------------------------------------
    wire [31:0] rdMux =
        cfgHit ? {24'h0, cfg_q[cfgSel]} :
        (idx == IdxPinIn) ? {27'h0, coreIn} :
        (idx == IdxPinOut) ? {27'h0, gpOut_q} :
        (idx == IdxIrqStat) ? {30'h0, stat_q} :
        (idx == IdxIrqMask) ? {30'h0, mask_q} :
        (idx == IdxDevDis) ? {24'h0, devDis_q} : ReadZero;
    // The answer comes one cycle after a request is taken.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            ack_q <= 1'b0;
            waitReq_q <= 1'b1;
        end else begin
            ack_q <= access;
            waitReq_q <= !access;
        end
    end
    // Read data are captured at the take edge and stand until the next read.
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            rd_q <= ReadZero;
        end else if (rdEn) begin
            rd_q <= rdMux;
        end
    end
    assign waitrequest = waitReq_q;
    assign readdata = rd_q;
    assign pinOut = pOut_q;
    assign pinOe = pOe_q;
    assign irq = irq_q;
    assign deviceDisable = devDis_q;
    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    a_lock_holds: assert property (
        @(posedge clk) disable iff (!rstnSync)
        lock43 |=> lock43)
        else $error("lock field changed");
    a_lock_input: assert property (
        @(posedge clk) disable iff (!rstnSync)
        lock43 |-> cfgIn[4] && !cfgInv[4])
        else $error("lock pin not input");
    a_dir_input: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[0][BitDir] |-> !cellOe[0])
        else $error("input pin driven");
    a_od_low: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[1][BitOdrv] && cellOe[1] |-> !cellOut[1])
        else $error("open drain drove high");
    a_gpin_read: assert property (
        @(posedge clk) disable iff (!rstnSync)
        !lock43 |-> coreIn[4] == (padLvl[4] ^ cfg_q[4][BitPol]))
        else $error("input polarity wrong");
    a_pme_low: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[3][BitAlt] && !cfg_q[3][BitPol] && !cfg_q[3][BitOdrv]
        |-> cellOut[3] == !powerEvent)
        else $error("power event level wrong");
    a_a20_route: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[0][BitAlt] |-> coreOut[0] == addressBit20Mask)
        else $error("mask not routed");
    a_dens_route: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[1][BitAlt] |-> coreOut[1] == driveDensitySelect0)
        else $error("density 0 not routed");
    a_dd_guard: assert property (
        @(posedge clk) disable iff (!rstnSync)
        lock43 && padLvl[4] |=> $stable(devDis_q))
        else $error("disable register written while pin high");
    a_ack_one: assert property (
        @(posedge clk) disable iff (!rstnSync)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("no answer in one cycle");
    a_edge_set: assert property (
        @(posedge clk) disable iff (!rstnSync)
        edgeEvt[0] |=> stat_q[0])
        else $error("edge lost");
    a_dens1_route: assert property (
        @(posedge clk) disable iff (!rstnSync)
        alt41 == Alt41Dens1 |-> coreOut[2] == driveDensitySelect1)
        else $error("density 1 not routed");
    a_irq41_gate: assert property (
        @(posedge clk) disable iff (!rstnSync)
        alt41 != Alt41Irq |-> !edgeEvt[0])
        else $error("pin 4.1 edge outside interrupt mode");
    a_irq43_gate: assert property (
        @(posedge clk) disable iff (!rstnSync)
        alt43 != Alt43Irq |-> !edgeEvt[1])
        else $error("pin 4.3 edge outside interrupt mode");
    a_edge43_set: assert property (
        @(posedge clk) disable iff (!rstnSync)
        edgeEvt[1] |=> stat_q[1])
        else $error("pin 4.3 edge lost");
    a_cfg_write: assert property (
        @(posedge clk) disable iff (!rstnSync)
        wrEn && idx == IdxPin37 |=> cfg_q[0] == ($past(wb) & CfgMask1))
        else $error("pin 3.7 configuration write lost");
    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (!rstnSync)
        rdEn && !cfgHit && idx < IdxPinIn |=> rd_q == ReadZero)
        else $error("unmapped read not zero");
    a_dir_output: assert property (
        @(posedge clk) disable iff (!rstnSync)
        !cfgIn[2] && !cfg_q[2][BitOdrv] |-> cellOe[2])
        else $error("push-pull output not driven");
    a_inv_drive: assert property (
        @(posedge clk) disable iff (!rstnSync)
        !cfg_q[4][BitOdrv] |-> cellOut[4] == (gpOut_q[4] ^ cfgInv[4]))
        else $error("output polarity wrong");
    a_od_release: assert property (
        @(posedge clk) disable iff (!rstnSync)
        cfg_q[4][BitOdrv] && !cfgIn[4]
        |-> cellOe[4] == !(gpOut_q[4] ^ cfgInv[4]))
        else $error("open drain enable wrong");
    a_dd_write: assert property (
        @(posedge clk) disable iff (!rstnSync)
        devDisWr |=> devDis_q == $past(wb))
        else $error("disable register write lost");
    a_pin_read: assert property (
        @(posedge clk) disable iff (!rstnSync)
        coreIn[0] == (padLvl[0] ^ cfg_q[0][BitPol]))
        else $error("pin 3.7 input polarity wrong");
    a_stat_clear: assert property (
        @(posedge clk) disable iff (!rstnSync)
        statRd && !edgeEvt[0] |=> !stat_q[0])
        else $error("status not cleared by read");
    a_irq_level: assert property (
        @(posedge clk) disable iff (!rstnSync)
        irq_q == |(stat_q & $past(mask_q)))
        else $error("interrupt level wrong");
    a_wait_idle: assert property (
        @(posedge clk) disable iff (!rstnSync)
        !(read || write) |=> waitrequest)
        else $error("answer without request");
endmodule // gpio_pin_config
`default_nettype wire

// File: gpio_cfg_pkg.sv
// Package for the five-pin configurable I/O block: offsets, fields, resets.
// Assumes a 25 MHz clock and an Avalon-MM register slave with 32-bit data.
package gpio_cfg_pkg;
    localparam int NumPins = 5;
    localparam int AddrW = 8;
    // Printed offsets are register indices; byte address is four times.
    localparam logic [7:0] IdxPin37 = 8'h3a;
    localparam logic [7:0] IdxPin40 = 8'h3b;
    localparam logic [7:0] IdxPin41 = 8'h3c;
    localparam logic [7:0] IdxPin42 = 8'h3d;
    localparam logic [7:0] IdxPin43 = 8'h3e;
    localparam logic [7:0] IdxPinIn = 8'h40;
    localparam logic [7:0] IdxPinOut = 8'h41;
    localparam logic [7:0] IdxIrqStat = 8'h42;
    localparam logic [7:0] IdxIrqMask = 8'h43;
    localparam logic [7:0] IdxDevDis = 8'h44;
    localparam int BitDir = 0;
    localparam int BitPol = 1;
    localparam int BitAlt = 2;
    localparam int BitAltHi = 3;
    localparam int BitOdrv = 7;
    localparam logic [7:0] CfgReset = 8'h01;
    localparam logic [7:0] CfgMask1 = 8'h87;
    localparam logic [7:0] CfgMask2 = 8'h8f;
    localparam logic [1:0] Alt41Dens1 = 2'h1;
    localparam logic [1:0] Alt41Irq = 2'h2;
    localparam logic [1:0] Alt43Lock = 2'h1;
    localparam logic [1:0] Alt43Irq = 2'h3;
    localparam logic [31:0] ReadZero = 32'h0000_0000;
endpackage

// File: gpio_pin_cell.sv
// One configurable pin: polarity, direction, driver type, input sync.
// Assumes the pin input is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell (
    // Clock and reset
    input wire logic clk,
    input wire logic rstnSync,
    // Configuration
    input wire logic cfgInput,
    input wire logic cfgInvert,
    input wire logic cfgOpenDrain,
    // Internal signals
    input wire logic coreOut,
    output logic coreIn,
    output logic padLevel,
    // Pad
    input wire logic padIn,
    output logic padOut,
    output logic padOe
);
    logic syncA_q;
    logic syncB_q;
    logic drive;
    always_ff @(posedge clk or negedge rstnSync) begin
        if (!rstnSync) begin
            syncA_q <= 1'b0;
            syncB_q <= 1'b0;
        end else begin
            syncA_q <= padIn;
            syncB_q <= syncA_q;
        end
    end
    assign padLevel = syncB_q;
    assign coreIn = syncB_q ^ cfgInvert;
    assign drive = coreOut ^ cfgInvert;
    // Open drain drives only low; push-pull drives both levels.
    assign padOut = cfgOpenDrain ? 1'b0 : drive;
    assign padOe = !cfgInput && (!cfgOpenDrain || !drive);
endmodule // gpio_pin_cell
`default_nettype wire

// File: pin_board.sv
// Board model for the five shared pins of the configuration block.
// Assumes every line has a pull-up, which open-drain use needs.
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    // Design side
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe,
    // Board drivers
    input wire logic [4:0] boardEn,
    input wire logic [4:0] boardVal,
    // Resolved lines
    output logic [4:0] pinLevel
);
    // The design drive wins, then the board, then the pull-up.
    assign pinLevel = (pinOe & pinOut) | (~pinOe & boardEn & boardVal)
        | (~pinOe & ~boardEn);
endmodule // pin_board
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the pin configuration block.
// Assumes the board model resolves each pin with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpio_cfg_pkg::*;
    logic clk = 0;
    logic rstn = 0;
    logic [9:0] address = '0;
    logic read = 0;
    logic write = 0;
    logic [31:0] writedata = '0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [3:0] altSrc = '0;
    logic [4:0] pinLevel;
    logic [4:0] pinOut;
    logic [4:0] pinOe;
    logic [4:0] boardEn = '0;
    logic [4:0] boardVal = '0;
    logic [7:0] devDis;
    logic irq;
    logic [31:0] q;
    int errors = 0;
    int checks = 0;

    always #20 clk = ~clk;

    gpio_pin_config #(.NPins(5)) i_dut (.clk(clk), .rstn(rstn),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .addressBit20Mask(altSrc[0]),
        .driveDensitySelect0(altSrc[1]), .driveDensitySelect1(altSrc[2]),
        .powerEvent(altSrc[3]), .pinIn(pinLevel), .pinOut(pinOut),
        .pinOe(pinOe), .deviceDisable(devDis), .irq(irq));

    pin_board i_board (.pinOut(pinOut), .pinOe(pinOe), .boardEn(boardEn),
        .boardVal(boardVal), .pinLevel(pinLevel));

    //------------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [7:0] d);
        address <= {a, 2'b00};
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        write <= 0;
        read <= 0;
        @(posedge clk);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic cfgN(input logic [7:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            bus(1, IdxPin37 + 8'(i), d);
        end
        tick(2);
    endtask

    task automatic end_sim;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        tick(4);
        for (int i = 0; i < 5; i++) begin
            bus(0, IdxPin37 + 8'(i), 0);
            chk(q, 32'h01);
        end
        chk(32'(pinOe), 32'h0);
        bus(1, 8'h3f, 8'hff);
        bus(0, 8'h3f, 0);
        chk(q, 32'h0);
        bus(1, IdxPin37, 8'hff);
        bus(0, IdxPin37, 0);
        chk(q, 32'h87);
        $display("test registers done");
        cfgN(8'h00, 5);
        bus(1, IdxPinOut, 8'h15);
        tick(2);
        chk(32'(pinOe), 32'h1f);
        chk(32'(pinLevel), 32'h15);
        cfgN(8'h02, 5);
        chk(32'(pinLevel), 32'h0a);
        cfgN(8'h80, 5);
        chk(32'(pinOe), 32'h0a);
        chk(32'(pinLevel), 32'h15);
        cfgN(8'h04, 4);
        for (int v = 0; v < 2; v++) begin
            altSrc <= {4{v[0]}};
            tick(3);
            chk(32'(pinLevel[3:0]), 32'({~v[0], {3{v[0]}}}));
        end
        $display("test outputs done");
        cfgN(8'h01, 5);
        boardEn <= 5'h1f;
        boardVal <= 5'h13;
        tick(5);
        bus(0, IdxPinIn, 0);
        chk(q, 32'h13);
        cfgN(8'h03, 5);
        tick(3);
        bus(0, IdxPinIn, 0);
        chk(q, 32'h0c);
        $display("test inputs done");
        bus(1, IdxPin41, 8'h09);
        bus(1, IdxPin43, 8'h0d);
        bus(1, IdxIrqMask, 8'h03);
        tick(4);
        bus(0, IdxIrqStat, 0);
        for (int k = 0; k < 2; k++) begin
            boardVal[2] <= !boardVal[2];
            tick(5);
            chk(32'(irq), 32'h1);
            bus(0, IdxIrqStat, 0);
            chk(q, 32'h01);
            tick(2);
            chk(32'(irq), 32'h0);
        end
        bus(1, IdxIrqMask, 8'h00);
        boardVal[4] <= 0;
        tick(5);
        chk(32'(irq), 32'h0);
        bus(0, IdxIrqStat, 0);
        chk(q, 32'h02);
        $display("test interrupts done");
        boardVal[4] <= 1;
        bus(1, IdxPin43, 8'h05);
        tick(3);
        bus(1, IdxDevDis, 8'h5a);
        tick(2);
        chk(32'(devDis), 32'h0);
        boardVal[4] <= 0;
        tick(5);
        bus(1, IdxDevDis, 8'h5a);
        tick(2);
        chk(32'(devDis), 32'h5a);
        bus(1, IdxPin43, 8'h0e);
        bus(0, IdxPin43, 0);
        chk(q & 32'h0c, 32'h04);
        chk(32'(pinOe[4]), 32'h0);
        bus(0, IdxPinIn, 0);
        chk(q & 32'h10, 32'h0);
        $display("test lock done");
        end_sim();
    end
endmodule // testbench
`default_nettype wire
